/* src/ifm_consts.svh */
/*
  Register offsets, field positions, reset values and timing counts
  for the interrupt flag and supply monitor block.
  Assumes a 25 MHz system clock.
*/
`ifndef IFM_CONSTS_SVH
`define IFM_CONSTS_SVH

// Register offsets (byte index on the plain register port)
`define IFM_ADDR_SUPPLY_MON 4'h0
`define IFM_ADDR_EDGE_SEL 4'h1
`define IFM_ADDR_PRI0 4'h2
`define IFM_ADDR_PRI1 4'h3
`define IFM_ADDR_PRI2 4'h4
`define IFM_ADDR_PRI3 4'h5
`define IFM_ADDR_GRP0 4'h6
`define IFM_ADDR_GRP1 4'h7
`define IFM_ADDR_GRP2 4'h8
`define IFM_ADDR_GRP3 4'h9
`define IFM_ADDR_GRP4 4'hA
`define IFM_ADDR_CTRL 4'hB

// Supply monitor control fields
`define IFM_SM_OUT_BIT 5
`define IFM_SM_EN_BIT 4
`define IFM_SM_MASK 8'h17
`define IFM_SM_RESET 8'h00

// Primary control 0 fields
`define IFM_P0_GIE_BIT 0
`define IFM_P0_MASK 8'h7F
// Two-nibble registers with upper two bits per nibble unused
`define IFM_HALF_MASK 8'h33
`define IFM_FULL_MASK 8'hFF
`define IFM_REG_RESET 8'h00

// Grouped control 3 fields
`define IFM_G3_LV_FLAG_BIT 4
`define IFM_G3_LV_EN_BIT 0

// Supply monitor timing
`define IFM_CLK_HZ 25000000
`define IFM_T_LVDS_NS 1000
`define IFM_T_LVD_NS 1000
`define IFM_STAB_CYC ((`IFM_T_LVDS_NS * 25 + 999) / 1000)
`define IFM_DELAY_CYC ((`IFM_T_LVD_NS * 25 + 999) / 1000)

`endif

/* src/ifm_irq_block.sv */
/*
  Interrupt request/enable registers, external edge detection and
  low supply monitor logic for a small microcontroller.
  Assumes a core that pulses irq_taken when it vectors, and an analog
  comparator giving supply_below for the chosen trip level.
*/
// The register offsets and the plain strobed port were chosen for this implementation.
`timescale 1ns/100ps
`include "ifm_consts.svh"
module ifm_irq_block
  import ifm_pkg::*;
#(
  parameter int PINS = 4,
  parameter int STAB_CYC = `IFM_STAB_CYC,
  parameter int DELAY_CYC = `IFM_DELAY_CYC
)
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // Register port
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // External interrupt pins
  input wire logic [PINS-1:0] ext_pin,
  // Internal event pulses
  input wire logic serial_event,
  input wire logic spi_event,
  input wire logic converter_event,
  input wire logic memory_write_event,
  input wire logic [1:0] time_base_event,
  input wire logic calendar_event,
  input wire logic [13:0] grouped_event,
  // Supply comparator and power state
  input wire logic supply_below,
  input wire logic sleep_mode,
  input wire logic idle_mode,
  // Core side
  input wire logic irq_taken,
  output logic irq_request,
  output logic wake_request,
  output logic comparator_enable,
  output logic [2:0] trip_level_select
);

  // Set wins over software write: new value with hardware sets ORed
  function automatic logic [7:0] merge(
    input logic [7:0] cur,
    input logic wr,
    input logic [7:0] wd,
    input logic [7:0] setb,
    input logic [7:0] mask
  );
    merge = ((wr ? wd : cur) | setb) & mask;
  endfunction

  // Qualifying edge for one pin
  function automatic logic edge_hit(
    input logic [1:0] sel,
    input logic prev,
    input logic now
  );
    edge_hit = ((sel == IFM_EDGE_RISE || sel == IFM_EDGE_BOTH) && !prev && now) ||
               ((sel == IFM_EDGE_FALL || sel == IFM_EDGE_BOTH) && prev && !now);
  endfunction

  // Register state
  logic [7:0] sm_q;
  logic [7:0] edge_q;
  logic [7:0] p0_q;
  logic [7:0] p1_q;
  logic [7:0] p2_q;
  logic [7:0] p3_q;
  logic [7:0] g0_q;
  logic [7:0] g1_q;
  logic [7:0] g2_q;
  logic [7:0] g3_q;
  logic [7:0] g4_q;

  // Pin sampling stages
  logic [PINS-1:0] pin_s1_q;
  logic [PINS-1:0] pin_s2_q;
  logic [PINS-1:0] pin_s3_q;

  logic out_flag_q;
  ifm_mon_t mon_q;
  logic [15:0] mon_cnt_q;
  logic lv_set_q;
  logic [7:0] rdata_q;
  logic irq_q;
  logic wake_q;
  logic cmp_en_q;

  // Decoded writes
  wire wr_sm = reg_wr && reg_addr == `IFM_ADDR_SUPPLY_MON;
  wire wr_edge = reg_wr && reg_addr == `IFM_ADDR_EDGE_SEL;
  wire wr_p0 = reg_wr && reg_addr == `IFM_ADDR_PRI0;
  wire wr_p1 = reg_wr && reg_addr == `IFM_ADDR_PRI1;
  wire wr_p2 = reg_wr && reg_addr == `IFM_ADDR_PRI2;
  wire wr_p3 = reg_wr && reg_addr == `IFM_ADDR_PRI3;
  wire wr_g0 = reg_wr && reg_addr == `IFM_ADDR_GRP0;
  wire wr_g1 = reg_wr && reg_addr == `IFM_ADDR_GRP1;
  wire wr_g2 = reg_wr && reg_addr == `IFM_ADDR_GRP2;
  wire wr_g3 = reg_wr && reg_addr == `IFM_ADDR_GRP3;
  wire wr_g4 = reg_wr && reg_addr == `IFM_ADDR_GRP4;

  // Edge detection on synchronised pins
  logic [PINS-1:0] pin_hit;
  always_comb
  begin
    for (int i = 0; i < PINS; i++)
      pin_hit[i] = edge_hit(edge_q[2*i +: 2], pin_s3_q[i], pin_s2_q[i]);
  end

  // Monitor active only when enabled and awake
  wire mon_on = sm_q[`IFM_SM_EN_BIT] && !sleep_mode;
  wire mon_run = mon_on && mon_q == IFM_MON_RUN;
  wire cnt_done = mon_cnt_q == 16'h0000;

  // Grouped flags (bits 7:4, or 5:4 in two-nibble registers) summarise into primary controls
  wire gf0 = |(g0_q[7:4] & g0_q[3:0]);
  wire gf1 = |(g1_q[5:4] & g1_q[1:0]);
  wire gf2 = |(g2_q[7:4] & g2_q[3:0]);
  wire gf3 = |(g3_q[5:4] & g3_q[1:0]);
  wire gf4 = |(g4_q[5:4] & g4_q[1:0]);

  // Hardware set vectors, independent of primary enables; group summaries use group enables
  wire [7:0] set_p0 = {1'b0, serial_event, pin_hit[1], pin_hit[0], 4'h0};
  wire [7:0] set_p1 = {converter_event, gf1, gf0, spi_event, 4'h0};
  wire [7:0] set_p2 = {gf3, time_base_event[1], time_base_event[0], gf2, 4'h0};
  wire [7:0] set_p3 = {gf4, calendar_event, pin_hit[3], pin_hit[2], 4'h0};

  // Grouped set vectors from their own event pulses
  wire [7:0] set_g0 = {grouped_event[3:0], 4'h0};
  wire [7:0] set_g1 = {2'b00, grouped_event[5:4], 4'h0};
  wire [7:0] set_g2 = {grouped_event[9:6], 4'h0};
  wire [7:0] set_g3 = {2'b00, memory_write_event, lv_set_q, 4'h0};
  wire [7:0] set_g4 = {2'b00, grouped_event[13:12], 4'h0};


  // Next register values; hardware sets win over writes
  wire [7:0] p0_d = merge(p0_q, wr_p0, reg_wdata, set_p0, `IFM_P0_MASK)
                    & ~({7'h00, irq_taken} << `IFM_P0_GIE_BIT);
  wire [7:0] p1_d = merge(p1_q, wr_p1, reg_wdata, set_p1, `IFM_FULL_MASK);
  wire [7:0] p2_d = merge(p2_q, wr_p2, reg_wdata, set_p2, `IFM_FULL_MASK);
  wire [7:0] p3_d = merge(p3_q, wr_p3, reg_wdata, set_p3, `IFM_FULL_MASK);
  wire [7:0] g0_d = merge(g0_q, wr_g0, reg_wdata, set_g0, `IFM_FULL_MASK);
  wire [7:0] g1_d = merge(g1_q, wr_g1, reg_wdata, set_g1, `IFM_HALF_MASK);
  wire [7:0] g2_d = merge(g2_q, wr_g2, reg_wdata, set_g2, `IFM_FULL_MASK);
  wire [7:0] g3_d = merge(g3_q, wr_g3, reg_wdata, set_g3, `IFM_HALF_MASK);
  wire [7:0] g4_d = merge(g4_q, wr_g4, reg_wdata, set_g4, `IFM_HALF_MASK);

  // Enabled and pending, per primary register
  wire [2:0] pend0 = p0_q[6:4] & p0_q[3:1];
  wire [3:0] pend1 = p1_q[7:4] & p1_q[3:0];
  wire [3:0] pend2 = p2_q[7:4] & p2_q[3:0];
  wire [3:0] pend3 = p3_q[7:4] & p3_q[3:0];
  wire any_pend = |{pend0, pend1, pend2, pend3};

  // Request gated by the global enable; a vectoring cycle masks it
  wire irq_d = p0_q[`IFM_P0_GIE_BIT] && any_pend && !irq_taken;

  // Flags newly raised by hardware; one already set cannot wake
  wire [2:0] rise0 = set_p0[6:4] & ~p0_q[6:4];
  wire [3:0] rise1 = set_p1[7:4] & ~p1_q[7:4];
  wire [3:0] rise2 = set_p2[7:4] & ~p2_q[7:4];
  wire [3:0] rise3 = set_p3[7:4] & ~p3_q[7:4];
  wire [1:0] rise_g3 = set_g3[5:4] & ~g3_q[5:4];
  wire new_flag = |{rise0, rise1, rise2, rise3, rise_g3};

  // Wake holds until the core leaves idle or sleep
  wire wake_d = (idle_mode || sleep_mode) && (wake_q || new_flag);

  // Readable views; unused bits masked to zero
  wire [7:0] sm_view = (sm_q & `IFM_SM_MASK) | ({7'h00, out_flag_q} << `IFM_SM_OUT_BIT);
  wire [7:0] p0_view = p0_q & `IFM_P0_MASK;
  wire [7:0] g1_view = g1_q & `IFM_HALF_MASK;
  wire [7:0] g3_view = g3_q & `IFM_HALF_MASK;
  wire [7:0] g4_view = g4_q & `IFM_HALF_MASK;
  wire [7:0] status_view = {5'h00, mon_run, irq_q, wake_q};

  // Read mux; unused bits masked to zero
  logic [7:0] rd_mux;
  always_comb
  begin
    case (reg_addr)
      `IFM_ADDR_SUPPLY_MON: rd_mux = sm_view;
      `IFM_ADDR_EDGE_SEL: rd_mux = edge_q;
      `IFM_ADDR_PRI0: rd_mux = p0_view;
      `IFM_ADDR_PRI1: rd_mux = p1_q;
      `IFM_ADDR_PRI2: rd_mux = p2_q;
      `IFM_ADDR_PRI3: rd_mux = p3_q;
      `IFM_ADDR_GRP0: rd_mux = g0_q;
      `IFM_ADDR_GRP1: rd_mux = g1_view;
      `IFM_ADDR_GRP2: rd_mux = g2_q;
      `IFM_ADDR_GRP3: rd_mux = g3_view;
      `IFM_ADDR_GRP4: rd_mux = g4_view;
      `IFM_ADDR_CTRL: rd_mux = status_view;
      default: rd_mux = 8'h00;
    endcase
  end

  // Read data only in the slot after a read strobe
  wire [7:0] rdata_d = reg_rd ? rd_mux : 8'h00;

  // Pin synchronisers; first stage only feeds the second
  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
    begin
      pin_s1_q <= '0;
      pin_s2_q <= '0;
      pin_s3_q <= '0;
    end
    else
    begin
      pin_s1_q <= ext_pin;
      pin_s2_q <= pin_s1_q;
      pin_s3_q <= pin_s2_q;
    end
  end

  // Control and edge registers
  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
    begin
      sm_q <= `IFM_SM_RESET;
      edge_q <= `IFM_REG_RESET;
    end
    else
    begin
      if (wr_sm)
        sm_q <= reg_wdata & `IFM_SM_MASK;
      if (wr_edge)
        edge_q <= reg_wdata;
    end
  end

  // Primary control registers; service clears global enable
  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
    begin
      p0_q <= `IFM_REG_RESET;
      p1_q <= `IFM_REG_RESET;
      p2_q <= `IFM_REG_RESET;
      p3_q <= `IFM_REG_RESET;
    end
    else
    begin
      p0_q <= p0_d;
      p1_q <= p1_d;
      p2_q <= p2_d;
      p3_q <= p3_d;
    end
  end

  // Grouped control registers
  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
    begin
      g0_q <= `IFM_REG_RESET;
      g1_q <= `IFM_REG_RESET;
      g2_q <= `IFM_REG_RESET;
      g3_q <= `IFM_REG_RESET;
      g4_q <= `IFM_REG_RESET;
    end
    else
    begin
      g0_q <= g0_d;
      g1_q <= g1_d;
      g2_q <= g2_d;
      g3_q <= g3_d;
      g4_q <= g4_d;
    end
  end

  // Monitor sequencer: settle, then run; flag follows comparator in both; delayed request in run
  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
    begin
      mon_q <= IFM_MON_OFF;
      mon_cnt_q <= 16'h0000;
      out_flag_q <= 1'b0;
      lv_set_q <= 1'b0;
    end
    else
    begin
      lv_set_q <= 1'b0;
      case (mon_q)
        IFM_MON_OFF:
        begin
          out_flag_q <= 1'b0;
          mon_cnt_q <= 16'(STAB_CYC - 1);
          if (mon_on)
            mon_q <= IFM_MON_SETTLE;
        end
        IFM_MON_SETTLE:
        begin
          out_flag_q <= supply_below;
          if (!mon_on)
            mon_q <= IFM_MON_OFF;
          else if (cnt_done)
          begin
            mon_q <= IFM_MON_RUN;
            mon_cnt_q <= 16'(DELAY_CYC - 1);
          end
          else
            mon_cnt_q <= mon_cnt_q - 16'h0001;
        end
        IFM_MON_RUN:
        begin
          out_flag_q <= supply_below;
          if (!mon_on)
            mon_q <= IFM_MON_OFF;
          else if (!out_flag_q)
            mon_cnt_q <= 16'(DELAY_CYC - 1);
          else if (cnt_done)
          begin
            lv_set_q <= 1'b1;
            mon_cnt_q <= 16'(DELAY_CYC - 1);
          end
          else
            mon_cnt_q <= mon_cnt_q - 16'h0001;
        end
        default: mon_q <= IFM_MON_OFF;
      endcase
    end
  end

  // Registered outputs
  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
    begin
      rdata_q <= 8'h00;
      irq_q <= 1'b0;
      wake_q <= 1'b0;
      cmp_en_q <= 1'b0;
    end
    else
    begin
      rdata_q <= rdata_d;
      irq_q <= irq_d;
      wake_q <= wake_d;
      cmp_en_q <= mon_on;
    end
  end

  assign reg_rdata = rdata_q;
  assign irq_request = irq_q;
  assign wake_request = wake_q;
  assign comparator_enable = cmp_en_q;
  assign trip_level_select = sm_q[2:0];

endmodule

/* src/ifm_pkg.sv */
/*
  Types for the interrupt flag and supply monitor block.
  Assumes ifm_consts.svh holds the numbers.
*/
package ifm_pkg;
  typedef enum logic [1:0] {IFM_EDGE_OFF, IFM_EDGE_RISE, IFM_EDGE_FALL, IFM_EDGE_BOTH} ifm_edge_t;
  typedef enum logic [1:0] {IFM_MON_OFF, IFM_MON_SETTLE, IFM_MON_RUN} ifm_mon_t;
endpackage

/* test/ifm_core_model.sv */
/*
  Core model: vectors on a pending request, alternately at once and late.
  Assumes the block drops its request after servicing.
*/
`timescale 1ns/100ps
module ifm_core_model
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // Interrupt handshake
  input wire logic irq_request,
  output logic irq_taken
);
  logic busy_q;
  logic slow_q;
  logic [1:0] wait_q;
  // Pulse once per request, then wait for it to drop
  always_ff @(posedge ref_clk or posedge reset)
    if (reset)
    begin
      irq_taken <= 1'b0;
      busy_q <= 1'b0;
      slow_q <= 1'b0;
      wait_q <= 2'h0;
    end
    else if (irq_taken)
    begin
      irq_taken <= 1'b0;
      busy_q <= 1'b1;
      slow_q <= !slow_q;
    end
    else if (busy_q)
      busy_q <= irq_request;
    else if (irq_request && wait_q == (slow_q ? 2'h3 : 2'h0))
    begin
      irq_taken <= 1'b1;
      wait_q <= 2'h0;
    end
    else if (irq_request)
      wait_q <= wait_q + 2'h1;
endmodule

/* test/ifm_irq_properties.sv */
/*
  Port checker for the interrupt flag and supply monitor block.
  Assumes one clock and the active high asynchronous reset.
*/
`timescale 1ns/100ps
module ifm_irq_checker
(
  // Clock, reset and register port
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  // Power state and core side
  input wire logic sleep_mode,
  input wire logic idle_mode,
  input wire logic irq_taken,
  input wire logic irq_request,
  input wire logic wake_request,
  input wire logic comparator_enable,
  input wire logic [2:0] trip_level_select
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);
  // Register port answers
  a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data outside read slot");
  a_mon_unused: assert property (reg_rd && reg_addr == 4'h0 |=> (reg_rdata & 8'hC8) == 8'h00)
    else $error("unused monitor bits set");
  a_pri0_top: assert property (reg_rd && reg_addr == 4'h2 |=> !reg_rdata[7])
    else $error("primary zero bit seven set");
  a_unmapped_zero: assert property (reg_rd && reg_addr > 4'hB |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  // Supply monitor outputs
  a_trip_write: assert property (reg_wr && reg_addr == 4'h0 |=> trip_level_select == $past(reg_wdata[2:0]))
    else $error("trip level not taken");
  a_enable_on: assert property ((reg_wr && reg_addr == 4'h0 && reg_wdata[4]) ##1 (!sleep_mode && !reg_wr)[*2]
    |-> comparator_enable)
    else $error("monitor not switched on");
  a_enable_off: assert property ((reg_wr && reg_addr == 4'h0 && !reg_wdata[4]) ##1 !reg_wr |=> !comparator_enable)
    else $error("monitor not switched off");
  a_sleep_off: assert property (sleep_mode |=> !comparator_enable)
    else $error("monitor runs asleep");
  a_sleep_flag: assert property (sleep_mode[*3] ##0 (reg_rd && reg_addr == 4'h0) |=> !reg_rdata[5])
    else $error("low flag set asleep");
  // Core side
  a_taken_clears: assert property ((irq_taken && !reg_wr) ##1 !reg_wr |=> !irq_request)
    else $error("request after servicing");
  a_wake_cause: assert property (wake_request |-> $past(idle_mode) || $past(sleep_mode))
    else $error("wake while running");
endmodule

bind ifm_irq_block ifm_irq_checker ifm_irq_checker_i (.ref_clk(ref_clk), .reset(reset), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .sleep_mode(sleep_mode),
  .idle_mode(idle_mode), .irq_taken(irq_taken), .irq_request(irq_request), .wake_request(wake_request),
  .comparator_enable(comparator_enable), .trip_level_select(trip_level_select));

/* test/testbench.sv */
/*
  Self-checking bench for the interrupt flag and supply monitor block.
  Assumes short settle and delay counts of 2 and 4 cycles.
*/
`timescale 1ns/100ps
module testbench;
  logic ref_clk, reset, reg_wr, reg_rd, supply_below, sleep_mode, idle_mode;
  logic [3:0] reg_addr, ext_pin;
  logic [7:0] reg_wdata, rd_q;
  logic [8:0] evt;
  logic [2:0] lvl;
  wire logic [7:0] reg_rdata;
  wire logic irq_taken, irq_request, wake_request, comparator_enable;
  wire logic [2:0] trip_level_select;
  int failures, num_checks, i, p, m;
  localparam logic [3:0] EV_ADDR [9] = '{4'h2, 4'h3, 4'h3, 4'h9, 4'h4, 4'h4, 4'h5, 4'h7, 4'hA};
  localparam int EV_BIT [9] = '{6, 4, 7, 5, 5, 6, 6, 4, 4};

  ifm_irq_block #(.STAB_CYC(2), .DELAY_CYC(4)) ifm_irq_block_i (.ref_clk(ref_clk), .reset(reset),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .ext_pin(ext_pin), .serial_event(evt[0]), .spi_event(evt[1]), .converter_event(evt[2]),
    .memory_write_event(evt[3]), .time_base_event(evt[5:4]), .calendar_event(evt[6]),
    .grouped_event({1'b0, evt[8], 7'h00, evt[7], 4'h0}), .supply_below(supply_below), .sleep_mode(sleep_mode),
    .idle_mode(idle_mode), .irq_taken(irq_taken), .irq_request(irq_request), .wake_request(wake_request),
    .comparator_enable(comparator_enable), .trip_level_select(trip_level_select));
  ifm_core_model ifm_core_model_i (.ref_clk(ref_clk), .reset(reset), .irq_request(irq_request),
    .irq_taken(irq_taken));

  // Clock
  initial
  begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end

  // Readable bits per register
  function automatic logic [7:0] rmask(input logic [3:0] a);
    case (a)
      4'h0: return 8'h17;
      4'h2: return 8'h7F;
      4'h7, 4'h9, 4'hA: return 8'h33;
      default: return 8'hFF;
    endcase
  endfunction

  // Register port cycles
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a);
    @(posedge ref_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    @(negedge ref_clk);
    rd_q = reg_rdata;
  endtask
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      failures++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk1(input logic got, input logic exp);
    chk8({7'h00, got}, {7'h00, exp});
  endtask
  // One pin edge, then flag readback and clear
  task automatic edge_step(input int pn, input logic lv, input logic e);
    @(posedge ref_clk);
    ext_pin[pn] <= lv;
    repeat (6) @(posedge ref_clk);
    rd(pn < 2 ? 4'h2 : 4'h5);
    chk1(rd_q[4 + pn % 2], e);
    wr(pn < 2 ? 4'h2 : 4'h5, 8'h00);
  endtask
  task automatic report_and_stop();
    $display("Checks %0d, failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // Main sequence
  initial
  begin
    {failures, num_checks, reset, reg_wr, reg_rd, reg_addr, reg_wdata} = {32'h0, 32'h0, 1'b1, 14'h0};
    {ext_pin, evt, supply_below, sleep_mode, idle_mode} = 16'h0000;
    void'($urandom(32'hAFA376AF));
    repeat (10) @(posedge ref_clk);
    reset <= 1'b0;
    for (i = 0; i < 16; i++)
    begin
      rd(i[3:0]);
      chk8(rd_q, 8'h00);
    end
    for (i = 0; i < 11; i++)
    begin
      m = $urandom;
      m[0] = m[0] && (i != 2);
      wr(i[3:0], m[7:0]);
      rd(i[3:0]);
      chk8(rd_q, m[7:0] & rmask(i[3:0]));
    end
    wr(4'hF, 8'hFF);
    rd(4'hF);
    chk8(rd_q, 8'h00);
    repeat (2) for (i = 0; i < 11; i++) wr(i[3:0], 8'h00);
    for (p = 0; p < 4; p++)
      for (m = 0; m < 4; m++)
      begin
        wr(4'h1, 8'(m << (2 * p)));
        edge_step(p, 1'b1, m[0]);
        edge_step(p, 1'b0, m[1]);
      end
    for (i = 0; i < 9; i++)
    begin
      @(posedge ref_clk);
      evt <= 9'h001 << i;
      @(posedge ref_clk);
      evt <= 9'h000;
      rd(EV_ADDR[i]);
      chk8(rd_q, 8'(1 << EV_BIT[i]));
      wr(EV_ADDR[i], 8'h00);
    end
    wr(4'h2, 8'h08);
    @(posedge ref_clk);
    evt <= 9'h001;
    @(posedge ref_clk);
    evt <= 9'h000;
    repeat (4) @(posedge ref_clk);
    chk1(irq_request, 1'b0);
    wr(4'h2, 8'h49);
    for (i = 0; i < 50 && irq_taken !== 1'b1; i++) @(posedge ref_clk);
    if (i == 50)
    begin
      failures++;
      report_and_stop();
    end
    repeat (4) @(posedge ref_clk);
    rd(4'h2);
    chk8(rd_q, 8'h48);
    lvl = 3'($urandom);
    @(posedge ref_clk);
    supply_below <= 1'b1;
    wr(4'h0, {4'h1, 1'b0, lvl});
    rd(4'h9);
    chk8(rd_q, 8'h00);
    repeat (20) @(posedge ref_clk);
    rd(4'h0);
    chk8(rd_q, {4'h3, 1'b0, lvl});
    rd(4'h9);
    chk8(rd_q, 8'h10);
    chk8({5'h00, trip_level_select}, {5'h00, lvl});
    @(posedge ref_clk);
    idle_mode <= 1'b1;
    repeat (3) @(posedge ref_clk);
    chk1(wake_request, 1'b0);
    supply_below <= 1'b0;
    repeat (3) @(posedge ref_clk);
    wr(4'h9, 8'h00);
    @(posedge ref_clk);
    supply_below <= 1'b1;
    repeat (10) @(posedge ref_clk);
    chk1(wake_request, 1'b1);
    idle_mode <= 1'b0;
    sleep_mode <= 1'b1;
    repeat (4) @(posedge ref_clk);
    rd(4'h0);
    chk8(rd_q, {4'h1, 1'b0, lvl});
    chk1(comparator_enable, 1'b0);
    @(posedge ref_clk);
    sleep_mode <= 1'b0;
    wr(4'h0, {5'h00, lvl});
    repeat (3) @(posedge ref_clk);
    chk1(comparator_enable, 1'b0);
    report_and_stop();
  end
endmodule
